/* File: rtl/tcc_top.sv */
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
module tcc_top
  import tcc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] RAW_RESULT,
  input wire logic IDLE_MODE,
  output logic [2:0] COMPARATOR_ON,
  output logic [2:0] POSITIVE_INPUT_SELECT,
  output logic [5:0] NEGATIVE_INPUT_SELECT,
  output logic [2:0] RESULT_PIN,
  output logic [2:0] RESULT_PIN_OE_N,
  output logic [2:0] EVENT_TRIGGER,
  output logic [2:0] EVENT_IRQ,
  output logic LADDER_POWER_ON,
  output logic LADDER_PIN_ENABLE,
  output logic LADDER_RANGE_SELECT,
  output logic LADDER_SOURCE_SELECT,
  output logic [3:0] LADDER_TAP_CODE
);
  tcc_state_s st;
  tcc_state_s next_st;
  tcc_apb_req_s req;
  logic [15:0] stat_view;
  logic do_write;
  logic do_read;

  // Bus request bundle
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

  // Status view built from unit state
  always_comb begin
    stat_view = 16'h0000;
    stat_view[TCC_B_IDLE] = st.idle_stop;
    for (int u = 0; u < TCC_UNITS; u++) begin
      stat_view[TCC_B_EVCOPY + u] = st.ctrl[u][TCC_B_EVT];
      stat_view[TCC_B_RESCOPY + u] = st.ctrl[u][TCC_B_RES];
    end
  end

  // Access phase qualifiers
  assign do_write = req.sel & req.enable & st.ready & req.write;
  assign do_read = req.sel & req.enable & ~st.ready & ~req.write;

  // Next state
  always_comb begin
    logic res;
    logic rise;
    logic fall;
    logic hit;
    logic [1:0] edge_sel;
    next_st = st;
    res = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    edge_sel = 2'b00;
    // One wait state, answer in second access cycle
    next_st.ready = req.sel & req.enable & ~st.ready;
    next_st.slverr = 1'b0;
    if (req.sel & req.enable & ~st.ready) begin
      case (req.addr)
        TCC_ADDR_CMP1, TCC_ADDR_CMP2, TCC_ADDR_CMP3, TCC_ADDR_STAT, TCC_ADDR_LADDER: next_st.slverr = 1'b0;
        default: next_st.slverr = 1'b1;
      endcase
    end
    if (do_read) begin
      case (req.addr)
        TCC_ADDR_CMP1: next_st.rdata = {16'h0000, st.ctrl[0] & (TCC_CMP_WMASK | 16'h0100)};
        TCC_ADDR_CMP2: next_st.rdata = {16'h0000, st.ctrl[1] & (TCC_CMP_WMASK | 16'h0100)};
        TCC_ADDR_CMP3: next_st.rdata = {16'h0000, st.ctrl[2] & (TCC_CMP_WMASK | 16'h0100)};
        TCC_ADDR_STAT: next_st.rdata = {16'h0000, stat_view};
        TCC_ADDR_LADDER: next_st.rdata = {16'h0000, st.ladder & TCC_LADDER_WMASK};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    // Register writes, unimplemented bits kept at zero
    if (do_write) begin
      case (req.addr)
        TCC_ADDR_CMP1: next_st.ctrl[0] = (req.wdata[15:0] & TCC_CMP_WMASK) | (st.ctrl[0] & 16'h0100);
        TCC_ADDR_CMP2: next_st.ctrl[1] = (req.wdata[15:0] & TCC_CMP_WMASK) | (st.ctrl[1] & 16'h0100);
        TCC_ADDR_CMP3: next_st.ctrl[2] = (req.wdata[15:0] & TCC_CMP_WMASK) | (st.ctrl[2] & 16'h0100);
        TCC_ADDR_STAT: next_st.idle_stop = req.wdata[TCC_B_IDLE];
        TCC_ADDR_LADDER: next_st.ladder = req.wdata[15:0] & TCC_LADDER_WMASK;
        default: next_st.ladder = st.ladder;
      endcase
    end
    // Per unit result, pin and event logic
    for (int u = 0; u < TCC_UNITS; u++) begin
      res = st.ctrl[u][TCC_B_ON] & (RAW_RESULT[u] ^ st.ctrl[u][TCC_B_INV]);
      next_st.ctrl[u][TCC_B_RES] = res;
      next_st.pin_level[u] = res;
      next_st.pin_drive_n[u] = ~(st.ctrl[u][TCC_B_ON] & st.ctrl[u][TCC_B_PIN]);
      next_st.prev_res[u] = st.ctrl[u][TCC_B_RES];
      rise = st.ctrl[u][TCC_B_RES] & ~st.prev_res[u];
      fall = ~st.ctrl[u][TCC_B_RES] & st.prev_res[u];
      edge_sel = st.ctrl[u][TCC_B_EDGE +: 2];
      case (edge_sel)
        TCC_EDGE_ANY: hit = rise | fall;
        TCC_EDGE_FALL: hit = st.ctrl[u][TCC_B_INV] ? rise : fall;
        TCC_EDGE_RISE: hit = st.ctrl[u][TCC_B_INV] ? fall : rise;
        TCC_EDGE_NONE: hit = 1'b0;
        default: hit = 1'b0;
      endcase
      hit = hit & st.ctrl[u][TCC_B_ON] & ~st.ctrl[u][TCC_B_EVT];
      // A set flag blocks hits, so a same-cycle software clear wins and the edge is lost
      if (hit) begin
        next_st.ctrl[u][TCC_B_EVT] = 1'b1;
      end
      next_st.trig[u] = hit;
      next_st.irq[u] = hit & ~(st.idle_stop & IDLE_MODE);
    end
  end

  // State register, synchronous reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st.ctrl <= {TCC_UNITS{TCC_CMP_RESET}};
      st.idle_stop <= TCC_IDLE_RESET;
      st.ladder <= TCC_LADDER_RESET;
      st.prev_res <= '0;
      st.trig <= '0;
      st.irq <= '0;
      st.pin_drive_n <= '1;
      st.pin_level <= '0;
      st.ready <= 1'b0;
      st.slverr <= 1'b0;
      st.rdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign PRDATA = st.rdata;
  assign PREADY = st.ready;
  assign PSLVERR = st.slverr;
  assign EVENT_TRIGGER = st.trig;
  assign EVENT_IRQ = st.irq;
  assign RESULT_PIN = st.pin_level;
  assign RESULT_PIN_OE_N = st.pin_drive_n;
  assign LADDER_POWER_ON = st.ladder[TCC_B_LPWR];
  assign LADDER_PIN_ENABLE = st.ladder[TCC_B_LPIN];
  assign LADDER_RANGE_SELECT = st.ladder[TCC_B_LRANGE];
  assign LADDER_SOURCE_SELECT = st.ladder[TCC_B_LSRC];
  assign LADDER_TAP_CODE = st.ladder[TCC_B_LTAP +: 4];

  // Unit control fields out to the analog muxes
  always_comb begin
    COMPARATOR_ON = '0;
    POSITIVE_INPUT_SELECT = '0;
    NEGATIVE_INPUT_SELECT = '0;
    for (int u = 0; u < TCC_UNITS; u++) begin
      COMPARATOR_ON[u] = st.ctrl[u][TCC_B_ON];
      POSITIVE_INPUT_SELECT[u] = st.ctrl[u][TCC_B_POS];
      NEGATIVE_INPUT_SELECT[2*u +: 2] = st.ctrl[u][TCC_B_NEG +: 2];
    end
  end
endmodule : tcc_top

/* File: rtl/tcc_pkg.sv */
// Behaviour
// - A comparator runs only while its on bit 15 is set.
// - Bit 14 set, with on bit 15 set, drives the result onto the unit's result pin.
// - Bit 13 inverts the result before bit, pin and event logic.
// - Bit 9 is set on the chosen edge and blocks further events until cleared.
// - Read-only bit 8 shows positive above negative, reversed when inverted.
// - Edge select 11 raises an event on any output change while flag clear.
// - Edge select 10: falling output edge, or rising when inverted.
// - Edge select 01: rising output edge, or falling when inverted.
// - Edge select 00 raises no trigger, event or interrupt.
// - Bit 4 picks ladder level or pin A for the positive input.
// - Two-bit field picks pin B, C, D or half band-gap for negative input.
// - Idle stop bit 15 of status keeps units running but silences interrupts in idle.
// - Status bits 10, 9, 8 copy event flags of units 3, 2, 1.
// - Status bits 2, 1, 0 copy result bits of units 3, 2, 1.
// - Ladder control bit 7 powers the reference generator.
// - Ladder bit 6 connects the reference level to its pin.
// - Ladder bit 5 picks 1/24 steps from zero or 1/32 steps from a quarter.
// - Ladder bit 4 takes span from reference pins or analog supply.
// - Ladder bits 3-0 pick one of 16 taps scaling the step.
// - Ladder upper byte and unimplemented comparator bits ignore writes, read zero.
package tcc_pkg;
  localparam int TCC_UNITS = 3;
  localparam logic [7:0] TCC_ADDR_CMP1 = 8'h00;
  localparam logic [7:0] TCC_ADDR_CMP2 = 8'h04;
  localparam logic [7:0] TCC_ADDR_CMP3 = 8'h08;
  localparam logic [7:0] TCC_ADDR_STAT = 8'h0c;
  localparam logic [7:0] TCC_ADDR_LADDER = 8'h10;
  // Comparator control field positions
  localparam int TCC_B_ON = 15;
  localparam int TCC_B_PIN = 14;
  localparam int TCC_B_INV = 13;
  localparam int TCC_B_EVT = 9;
  localparam int TCC_B_RES = 8;
  localparam int TCC_B_EDGE = 6;
  localparam int TCC_B_POS = 4;
  localparam int TCC_B_NEG = 0;
  // Status field positions
  localparam int TCC_B_IDLE = 15;
  localparam int TCC_B_EVCOPY = 8;
  localparam int TCC_B_RESCOPY = 0;
  // Ladder field positions
  localparam int TCC_B_LPWR = 7;
  localparam int TCC_B_LPIN = 6;
  localparam int TCC_B_LRANGE = 5;
  localparam int TCC_B_LSRC = 4;
  localparam int TCC_B_LTAP = 0;
  // Writable masks
  localparam logic [15:0] TCC_CMP_WMASK = 16'he2d3;
  localparam logic [15:0] TCC_STAT_WMASK = 16'h8000;
  localparam logic [15:0] TCC_LADDER_WMASK = 16'h00ff;
  // Reset values
  localparam logic [15:0] TCC_CMP_RESET = 16'h0000;
  localparam logic [15:0] TCC_LADDER_RESET = 16'h0000;
  localparam logic TCC_IDLE_RESET = 1'b0;
  // Edge select codes
  typedef enum logic [1:0] {
    TCC_EDGE_NONE = 2'b00,
    TCC_EDGE_RISE = 2'b01,
    TCC_EDGE_FALL = 2'b10,
    TCC_EDGE_ANY = 2'b11
  } tcc_edge_e;
  // APB request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tcc_apb_req_s;
  // Whole block state
  typedef struct packed {
    logic [TCC_UNITS-1:0][15:0] ctrl;
    logic idle_stop;
    logic [15:0] ladder;
    logic [TCC_UNITS-1:0] prev_res;
    logic [TCC_UNITS-1:0] trig;
    logic [TCC_UNITS-1:0] irq;
    logic [TCC_UNITS-1:0] pin_drive_n;
    logic [TCC_UNITS-1:0] pin_level;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } tcc_state_s;
endpackage : tcc_pkg

/* File: tb/tcc_analog.sv */
`timescale 1ns/100ps
module tcc_analog (
  input wire logic CLK,
  input wire logic [2:0] level,
  output logic [2:0] RAW_RESULT
);
  // Decision settles one clock after the levels move
  always_ff @(posedge CLK) begin
    RAW_RESULT <= level;
  end
endmodule : tcc_analog

/* File: tb/tcc_chk.sv */
`timescale 1ns/100ps
module tcc_chk (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [2:0] COMPARATOR_ON,
  input wire logic [2:0] RESULT_PIN,
  input wire logic [2:0] RESULT_PIN_OE_N,
  input wire logic [2:0] EVENT_TRIGGER,
  input wire logic [2:0] EVENT_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Bus timing and error framing
  AST_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  AST_PULSE: assert property (PREADY |=> !PREADY) else $error("ready too long");
  AST_ERR: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_UPPER: assert property (PREADY |-> PRDATA[31:16] == 16'h0000) else $error("upper half set");
  // Unit behaviour at the pins; the off check starts one cycle after the unit goes off
  AST_OFF: assert property (!COMPARATOR_ON[0] && !$past(COMPARATOR_ON[0]) |-> !RESULT_PIN[0] && RESULT_PIN_OE_N[0]) else $error("off unit drives");
  AST_BLOCK: assert property (EVENT_TRIGGER[0] |=> !EVENT_TRIGGER[0] [*2]) else $error("event repeat");
  AST_SRC: assert property (EVENT_TRIGGER[0] |-> $past(COMPARATOR_ON[0]) && $past(RESULT_PIN[0]) != $past(RESULT_PIN[0], 2)) else $error("event without change");
  AST_IRQ: assert property (EVENT_IRQ[2] |-> EVENT_TRIGGER[2]) else $error("irq alone");
  AST_RST: assert property ($rose(RSTN) |-> COMPARATOR_ON == 3'h0 && RESULT_PIN_OE_N == 3'h7) else $error("reset state");
  // Main scenarios
  cover property (EVENT_TRIGGER[0]);
  cover property (PSLVERR);
  cover property (EVENT_TRIGGER[2] && !EVENT_IRQ[2]);
endmodule : tcc_chk
bind tcc_top tcc_chk u_chk (.CLK, .RSTN, .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR, .COMPARATOR_ON,
  .RESULT_PIN, .RESULT_PIN_OE_N, .EVENT_TRIGGER, .EVENT_IRQ);

/* File: tb/test_tcc_top.sv */
`timescale 1ns/100ps
module test_tcc_top
  import tcc_pkg::*;
;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, IDLE_MODE = 0, PREADY, PSLVERR, e;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic [2:0] RAW_RESULT, lvl = 3'h0, con, pis, rp, roe, trg, irq;
  logic [5:0] nis;
  logic [3:0] lp, ltc;
  int miscompares = 0, n_checks = 0, nt[3] = '{0, 0, 0}, ni[3] = '{0, 0, 0};
  always #50 CLK = ~CLK;
  tcc_analog ana (.CLK, .level(lvl), .RAW_RESULT);
  tcc_top DUT (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .RAW_RESULT, .IDLE_MODE, .COMPARATOR_ON(con), .POSITIVE_INPUT_SELECT(pis), .NEGATIVE_INPUT_SELECT(nis),
    .RESULT_PIN(rp), .RESULT_PIN_OE_N(roe), .EVENT_TRIGGER(trg), .EVENT_IRQ(irq), .LADDER_POWER_ON(lp[3]),
    .LADDER_PIN_ENABLE(lp[2]), .LADDER_RANGE_SELECT(lp[1]), .LADDER_SOURCE_SELECT(lp[0]), .LADDER_TAP_CODE(ltc));
  // Event pulse counters
  always @(negedge CLK) begin
    for (int u = 0; u < 3; u++) begin
      nt[u] += trg[u];
      ni[u] += irq[u];
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0, d};
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("[ERR] %0t no ready", $time);
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [15:0] x);
    apb(0, a, 16'h0);
    chk(r, {16'h0, x});
  endtask : rd
  task wt;
    repeat (5) @(posedge CLK);
  endtask : wt
  task t_reset;
    for (int a = 0; a < 20; a += 4) rd(a[7:0], 16'h0);
    apb(0, 8'h14, 16'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask : t_reset
  task t_regs;
    apb(1, TCC_ADDR_CMP2, 16'h7fff);
    rd(TCC_ADDR_CMP2, 16'h62d3);
    chk({con, pis, nis, roe}, 15'h0467);
    rd(TCC_ADDR_STAT, 16'h0200);
    for (int c = 0; c < 4; c++) begin
      apb(1, TCC_ADDR_CMP2, c[15:0]);
      @(negedge CLK);
      chk(nis[3:2], c[1:0]);
    end
    apb(1, TCC_ADDR_LADDER, 16'hffa5);
    rd(TCC_ADDR_LADDER, 16'h00a5);
    chk({lp, ltc}, 8'ha5);
  endtask : t_regs
  task t_edge;
    int b;
    logic f;
    for (int c = 0; c < 4; c++) for (int i = 0; i < 2; i++) begin
      apb(1, TCC_ADDR_CMP1, {2'b10, i[0], 13'h0});
      apb(1, TCC_ADDR_CMP1, {2'b10, i[0], 5'h0, c[1:0], 6'h0});
      // Output rises first when plain, falls first when inverted
      f = c == 3 || c == 1;
      b = nt[0];
      lvl[0] <= 1;
      wt;
      chk(nt[0] - b, f);
      b = nt[0];
      lvl[0] <= 0;
      wt;
      chk(nt[0] - b, !f && c != 0);
      rd(TCC_ADDR_CMP1, {2'b10, i[0], 3'h0, c != 0, i[0], c[1:0], 6'h0});
      apb(1, TCC_ADDR_CMP1, 16'h0);
    end
  endtask : t_edge
  task t_idle;
    int b, bi;
    apb(1, TCC_ADDR_STAT, 16'hffff);
    rd(TCC_ADDR_STAT, 16'h8000);
    IDLE_MODE <= 1;
    apb(1, TCC_ADDR_CMP3, 16'hc0c0);
    b = nt[2];
    bi = ni[2];
    lvl[2] <= 1;
    wt;
    chk(nt[2] - b, 32'h1);
    chk(ni[2] - bi, 32'h0);
    chk({30'h0, rp[2], roe[2]}, 32'h2);
    rd(TCC_ADDR_STAT, 16'h8404);
    apb(1, TCC_ADDR_CMP3, 16'hc0c0);
    IDLE_MODE <= 0;
    lvl[2] <= 0;
    wt;
    chk(nt[2] - b, 32'h2);
    chk(ni[2] - bi, 32'h1);
  endtask : t_idle
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge CLK);
    RSTN <= 1;
    t_reset;
    t_regs;
    t_edge;
    t_idle;
    end_sim;
  end
  // Watchdog
  initial begin
    #1000000;
    miscompares++;
    end_sim;
  end
endmodule : test_tcc_top
